// >>> include/usart_pkg.sv
/*
   Constants, field positions, reset values and state codes for the serial
   transceiver core. Assumes a 32-bit APB register bus with word offsets.
*/
// Contract
// - Baud counter reloads at zero and on low-byte write.
// - Baud tick each time the counter reaches zero.
// - Transmitter divides ticks by 16, 8 or 2.
// - Receiver recovery uses 16, 8 or 2 states.
// - Baud divisor is twelve bits, 0 to 4095.
// - Mode bit selects async or sync; pin sync only.
// - Double speed only affects asynchronous mode timing.
// - Slave clock synchronised then edge detected, two cycles.
// - Polarity picks change edge and sample edge.
// - Frames: start, 5-9 data, parity option, 1-2 stops.
// - Start low, data LSB first, parity, stops high.
// - Line idles high or carries next frame directly.
// - One frame format shared by both directions.
// - Second stop ignored; frame error on first stop low.
// - Parity is data XOR, inverted for odd.
// - One write buffer ahead of transmit shifter.
// - Two-entry receive FIFO storing status with data.
// - Full FIFO holds character in shifter until start.
// - Receiver reports frame, overrun and parity errors.
// - Size code 7 means nine bits; ninth from register.
package usart_pkg;
   // Register byte offsets.
   localparam logic [7:0] OFS_DATA  = 8'h00;  // Data buffer register.
   localparam logic [7:0] OFS_CSA   = 8'h04;  // Control and status A.
   localparam logic [7:0] OFS_CSB   = 8'h08;  // Control and status B.
   localparam logic [7:0] OFS_CSC   = 8'h0C;  // Control and status C.
   localparam logic [7:0] OFS_BAUDL = 8'h10;  // Baud divisor low byte.
   localparam logic [7:0] OFS_BAUDH = 8'h14;  // Baud divisor high nibble.
   // Control and status A bit positions.
   localparam int CSA_RX_AVAIL = 7;  // Receive FIFO holds data.
   localparam int CSA_TX_DONE  = 6;  // Transmission complete, write one to clear.
   localparam int CSA_TX_EMPTY = 5;  // Transmit buffer empty.
   localparam int CSA_FERR     = 4;  // Frame error of FIFO head.
   localparam int CSA_OVR      = 3;  // Overrun of FIFO head.
   localparam int CSA_PE       = 2;  // Parity error of FIFO head.
   localparam int CSA_DBL      = 1;  // Double speed select.
   // Control and status B bit positions.
   localparam int CSB_RX_EN = 4;  // Receiver enable.
   localparam int CSB_TX_EN = 3;  // Transmitter enable.
   localparam int CSB_CSZ2  = 2;  // Character size code bit 2.
   localparam int CSB_RX9   = 1;  // Received ninth bit of FIFO head.
   localparam int CSB_TX9   = 0;  // Ninth transmit bit.
   // Control and status C bit positions.
   localparam int CSC_CLK_DIR = 7;  // Clock pin direction, one is master.
   localparam int CSC_SYNC    = 6;  // Synchronous mode select.
   localparam int CSC_PAR_HI  = 5;  // Parity mode high bit.
   localparam int CSC_PAR_LO  = 4;  // Parity mode low bit.
   localparam int CSC_STOP2   = 3;  // Two stop bits.
   localparam int CSC_CSZ_HI  = 2;  // Character size code bit 1.
   localparam int CSC_CSZ_LO  = 1;  // Character size code bit 0.
   localparam int CSC_CPOL    = 0;  // Clock polarity.
   // Reset values.
   localparam logic [7:0] CSA_RST = 8'h00;  // Normal speed.
   localparam logic [7:0] CSB_RST = 8'h00;  // Both directions disabled.
   localparam logic [7:0] CSC_RST = 8'h06;  // Eight data bits, no parity, one stop.
   localparam logic [11:0] BAUD_RST = 12'h000;  // Divisor after reset.
   // Timing counts in baud ticks, each stored as the count minus one.
   localparam logic [3:0] DIV_NORMAL  = 4'hF;  // Sixteen ticks per bit.
   localparam logic [3:0] DIV_DOUBLE  = 4'h7;  // Eight ticks per bit.
   localparam logic [3:0] HALF_NORMAL = 4'h7;  // Half bit, normal speed.
   localparam logic [3:0] HALF_DOUBLE = 4'h3;  // Half bit, double speed.
   // Frame format codes.
   localparam logic [2:0] CSZ_NINE = 3'h7;  // Nine data bits.
   localparam logic [3:0] BASE_BITS = 4'h5;  // Data bits for size code zero.
   localparam logic [3:0] MAX_BITS  = 4'h9;  // Data bits for the nine-bit code.
   // Receiver states.
   typedef enum logic [2:0] {
      RX_IDLE  = 3'b001,
      RX_START = 3'b010,
      RX_BITS  = 3'b100
   } rx_state_e;
endpackage : usart_pkg

// >>> src/usart_core.sv
/*
   Serial transceiver core: APB register slave, baud generator, synchronous
   clock handling, buffered transmitter and two-entry receive FIFO.
   Assumes rxd and the APB inputs are synchronous to core_clk; lck_in may be
   asynchronous and is synchronised here.
*/
// The APB register port and the address map are this design's own decisions.
`timescale 1ns/1ps
module usart_core
   import usart_pkg::*;
(
   input  wire logic        core_clk,
   input  wire logic        rstn,
   input  wire logic [7:0]  paddr,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        rxd,
   output logic             txd,
   input  wire logic        lck_in,
   output logic             lck_out,
   output logic             lck_oe
);
   // Register state.
   logic [7:0]  csa_r, csa_nxt;      // Writable part of status A (speed bit).
   logic [7:0]  csb_r, csb_nxt;      // Enables, size bit 2, ninth transmit bit.
   logic [7:0]  csc_r, csc_nxt;      // Mode, parity, stops, size, polarity.
   logic [11:0] baud_r, baud_nxt;    // Baud divisor.
   logic [31:0] prdata_r, prdata_nxt;
   logic        pready_r, pready_nxt;
   logic        pslverr_r, pslverr_nxt;
   // Bus events.
   logic        acc, wr_data, rd_data, wr_baudl, clr_done, hit;
   // Frame format decoded from the registers.
   logic [2:0]  csz;                 // Character size code.
   logic [3:0]  nbits;               // Data bits per frame.
   logic        par_en, par_odd, two_stop, sync, master, dbl, pol;
   logic [3:0]  div_m1, half_m1;     // Ticks per bit and half bit, minus one.
   // Clock generation state.
   logic [11:0] bcnt_r, bcnt_nxt;    // Baud down-counter.
   logic        lck_r, lck_nxt;      // Master transfer clock.
   logic        lck_oe_r, lck_oe_nxt;
   logic        xs1_r, xs2_r, xs3_r; // Slave clock synchroniser and edge stage.
   logic [3:0]  txpre_r, txpre_nxt;  // Transmit prescaler.
   logic        tick, clk_rise, clk_fall, chg_ev, smp_ev, tx_step;
   // Transmitter state.
   logic [8:0]  txbuf_r, txbuf_nxt;
   logic        txfull_r, txfull_nxt;
   logic [11:0] txsh_r, txsh_nxt;
   logic [3:0]  txcnt_r, txcnt_nxt;
   logic        txbusy_r, txbusy_nxt;
   logic        txd_r, txd_nxt;
   logic        txdone_r, txdone_nxt;
   // Receiver state.
   rx_state_e   rxst_r, rxst_nxt;
   logic [3:0]  rxph_r, rxph_nxt;    // Tick phase within a bit.
   logic [3:0]  rxbit_r, rxbit_nxt;  // Bits taken after the start bit.
   logic [9:0]  rxsh_r, rxsh_nxt;    // Data and parity bits as taken.
   logic        held_r, held_nxt;    // Third level: character kept in shifter.
   logic [11:0] hold_r, hold_nxt;    // Held entry.
   logic        povr_r, povr_nxt;    // Overrun to tag the next stored entry.
   logic [11:0] fifo_r [2];          // Entries: {fe, dor, pe, ninth, data}.
   logic [11:0] fifo_nxt [2];
   logic        wp_r, wp_nxt, rp_r, rp_nxt;
   logic [1:0]  fcnt_r, fcnt_nxt;
   logic [11:0] head;

   // Builds the bits after the start bit: data LSB first, parity, then ones.
   function automatic logic [11:0] build_frame(input logic [8:0] d, input logic [3:0] n,
                                                input logic pen, input logic odd);
      logic [11:0] f;
      logic        p;
      f = 12'hFFF;
      p = odd;
      for (int i = 0; i < 9; i++) begin
         if (4'(i) < n) begin
            f[i] = d[i];
            p    = p ^ d[i];
         end
      end
      if (pen) begin
         f[n] = p;
      end
      return f;
   endfunction : build_frame

   // Parity of the first n bits of a received word, inverted for odd.
   function automatic logic calc_par(input logic [8:0] d, input logic [3:0] n,
                                     input logic odd);
      logic p;
      p = odd;
      for (int i = 0; i < 9; i++) begin
         if (4'(i) < n) begin
            p = p ^ d[i];
         end
      end
      return p;
   endfunction : calc_par

   // Format decode, shared by receiver and transmitter.
   assign csz      = {csb_r[CSB_CSZ2], csc_r[CSC_CSZ_HI], csc_r[CSC_CSZ_LO]};
   assign nbits    = (csz == CSZ_NINE) ? MAX_BITS : BASE_BITS + {2'b00, csz[1:0]};
   assign par_en   = csc_r[CSC_PAR_HI];
   assign par_odd  = csc_r[CSC_PAR_LO];
   assign two_stop = csc_r[CSC_STOP2];
   assign sync     = csc_r[CSC_SYNC];
   assign master   = sync & csc_r[CSC_CLK_DIR];
   assign dbl      = csa_r[CSA_DBL] & ~sync;
   assign pol      = csc_r[CSC_CPOL];
   assign div_m1   = dbl ? DIV_DOUBLE : DIV_NORMAL;
   assign half_m1  = dbl ? HALF_DOUBLE : HALF_NORMAL;

   // Bus events; a transfer completes at the edge where pready is seen.
   assign acc      = psel & penable & pready_r;
   assign wr_data  = acc & pwrite & (paddr == OFS_DATA);
   assign rd_data  = acc & ~pwrite & (paddr == OFS_DATA);
   assign wr_baudl = acc & pwrite & (paddr == OFS_BAUDL);
   assign clr_done = acc & pwrite & (paddr == OFS_CSA) & pwdata[CSA_TX_DONE];
   assign hit      = (paddr == OFS_DATA) | (paddr == OFS_CSA) | (paddr == OFS_CSB) |
                     (paddr == OFS_CSC) | (paddr == OFS_BAUDL) | (paddr == OFS_BAUDH);
   assign head     = fifo_r[rp_r];

   // APB slave: answer one cycle after setup, registers written on completion.
   always_comb begin
      csa_nxt     = csa_r;
      csb_nxt     = csb_r;
      csc_nxt     = csc_r;
      baud_nxt    = baud_r;
      prdata_nxt  = prdata_r;
      pready_nxt  = psel & ~penable;
      pslverr_nxt = psel & ~penable & ~hit;
      // Read data is prepared in the setup cycle.
      if (psel & ~penable) begin
         prdata_nxt = 32'h0000_0000;
         case (paddr)
            OFS_DATA:  prdata_nxt[7:0] = head[7:0];
            OFS_CSA: begin
               prdata_nxt[CSA_RX_AVAIL] = fcnt_r != 2'b00;
               prdata_nxt[CSA_TX_DONE]  = txdone_r;
               prdata_nxt[CSA_TX_EMPTY] = ~txfull_r;
               prdata_nxt[CSA_FERR]     = (fcnt_r != 2'b00) & head[11];
               prdata_nxt[CSA_OVR]      = (fcnt_r != 2'b00) & head[10];
               prdata_nxt[CSA_PE]       = (fcnt_r != 2'b00) & head[9];
               prdata_nxt[CSA_DBL]      = csa_r[CSA_DBL];
            end
            OFS_CSB: begin
               prdata_nxt[7:0]     = csb_r;
               prdata_nxt[CSB_RX9] = head[8];
            end
            OFS_CSC:   prdata_nxt[7:0] = csc_r;
            OFS_BAUDL: prdata_nxt[7:0] = baud_r[7:0];
            OFS_BAUDH: prdata_nxt[3:0] = baud_r[11:8];
            default:   prdata_nxt = 32'h0000_0000;
         endcase
      end
      // Register writes take effect at the completing edge.
      if (acc & pwrite) begin
         case (paddr)
            OFS_CSA:   csa_nxt[CSA_DBL] = pwdata[CSA_DBL];
            OFS_CSB: begin
               csb_nxt = {3'b000, pwdata[4:0]};
               csb_nxt[CSB_RX9] = 1'b0;
            end
            OFS_CSC:   csc_nxt = pwdata[7:0];
            OFS_BAUDL: baud_nxt[7:0] = pwdata[7:0];
            OFS_BAUDH: baud_nxt[11:8] = pwdata[3:0];
            default:   csa_nxt = csa_r;
         endcase
      end
   end

   // Registers of the bus slave.
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         csa_r     <= CSA_RST;
         csb_r     <= CSB_RST;
         csc_r     <= CSC_RST;
         baud_r    <= BAUD_RST;
         prdata_r  <= 32'h0000_0000;
         pready_r  <= 1'b0;
         pslverr_r <= 1'b0;
      end else begin
         csa_r     <= csa_nxt;
         csb_r     <= csb_nxt;
         csc_r     <= csc_nxt;
         baud_r    <= baud_nxt;
         prdata_r  <= prdata_nxt;
         pready_r  <= pready_nxt;
         pslverr_r <= pslverr_nxt;
      end
   end

   // Clock events: baud tick, master clock edges or detected slave edges.
   assign tick     = bcnt_r == 12'h000;
   assign clk_rise = master ? (tick & ~lck_r) : (xs2_r & ~xs3_r);
   assign clk_fall = master ? (tick & lck_r) : (~xs2_r & xs3_r);
   assign chg_ev   = pol ? clk_fall : clk_rise;
   assign smp_ev   = pol ? clk_rise : clk_fall;
   assign tx_step  = sync ? chg_ev : (tick & (txpre_r == div_m1));

   // Next values of the clock generator.
   always_comb begin
      // Reload at zero or on a low-byte write, otherwise count down.
      if (wr_baudl) begin
         bcnt_nxt = {baud_r[11:8], pwdata[7:0]};
      end else if (tick) begin
         bcnt_nxt = baud_r;
      end else begin
         bcnt_nxt = bcnt_r - 12'h001;
      end
      // Master clock toggles each tick, so a bit spans two ticks.
      lck_nxt    = master ? (lck_r ^ tick) : pol;
      lck_oe_nxt = master;
      if (sync | ~tick) begin
         txpre_nxt = sync ? 4'h0 : txpre_r;
      end else begin
         txpre_nxt = (txpre_r == div_m1) ? 4'h0 : txpre_r + 4'h1;
      end
   end

   // Registers of the clock generator; xs1 feeds only xs2.
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         bcnt_r   <= BAUD_RST;
         lck_r    <= 1'b0;
         lck_oe_r <= 1'b0;
         xs1_r    <= 1'b0;
         xs2_r    <= 1'b0;
         xs3_r    <= 1'b0;
         txpre_r  <= 4'h0;
      end else begin
         bcnt_r   <= bcnt_nxt;
         lck_r    <= lck_nxt;
         lck_oe_r <= lck_oe_nxt;
         xs1_r    <= lck_in;
         xs2_r    <= xs1_r;
         xs3_r    <= xs2_r;
         txpre_r  <= txpre_nxt;
      end
   end

   // Transmitter: buffer, shifter and line driver.
   always_comb begin
      txbuf_nxt  = txbuf_r;
      txfull_nxt = txfull_r;
      txsh_nxt   = txsh_r;
      txcnt_nxt  = txcnt_r;
      txbusy_nxt = txbusy_r;
      txd_nxt    = txd_r;
      txdone_nxt = txdone_r & ~clr_done;
      // A write while the buffer is still full is dropped.
      if (wr_data & ~txfull_r) begin
         txbuf_nxt  = {csb_r[CSB_TX9], pwdata[7:0]};
         txfull_nxt = 1'b1;
      end
      if (~csb_r[CSB_TX_EN]) begin
         txd_nxt    = 1'b1;
         txcnt_nxt  = 4'h0;
         txbusy_nxt = 1'b0;
      end else if (tx_step) begin
         if (txcnt_r != 4'h0) begin
            txd_nxt   = txsh_r[0];
            txsh_nxt  = {1'b1, txsh_r[11:1]};
            txcnt_nxt = txcnt_r - 4'h1;
         end else if (txfull_r) begin
            // Next frame follows the last stop bit with no gap.
            txd_nxt    = 1'b0;
            txsh_nxt   = build_frame(txbuf_r, nbits, par_en, par_odd);
            txcnt_nxt  = nbits + {3'b000, par_en} + {3'b000, two_stop} + 4'h1;
            txfull_nxt = 1'b0;
            txbusy_nxt = 1'b1;
         end else begin
            txd_nxt = 1'b1;
            if (txbusy_r) begin
               txbusy_nxt = 1'b0;
               txdone_nxt = 1'b1;
            end
         end
      end
   end

   // Registers of the transmitter.
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         txbuf_r  <= 9'h000;
         txfull_r <= 1'b0;
         txsh_r   <= 12'hFFF;
         txcnt_r  <= 4'h0;
         txbusy_r <= 1'b0;
         txd_r    <= 1'b1;
         txdone_r <= 1'b0;
      end else begin
         txbuf_r  <= txbuf_nxt;
         txfull_r <= txfull_nxt;
         txsh_r   <= txsh_nxt;
         txcnt_r  <= txcnt_nxt;
         txbusy_r <= txbusy_nxt;
         txd_r    <= txd_nxt;
         txdone_r <= txdone_nxt;
      end
   end

   // Receiver: start detection, bit sampling, FIFO and held third level.
   always_comb begin
      logic       samp, push, pop, ferr, pe;
      logic [8:0] dat;
      logic [11:0] entry;
      rxst_nxt  = rxst_r;
      rxph_nxt  = rxph_r;
      rxbit_nxt = rxbit_r;
      rxsh_nxt  = rxsh_r;
      held_nxt  = held_r;
      hold_nxt  = hold_r;
      povr_nxt  = povr_r;
      fifo_nxt  = fifo_r;
      samp      = 1'b0;
      push      = 1'b0;
      ferr      = 1'b0;
      pe        = 1'b0;
      dat       = 9'h000;
      entry     = hold_r;
      pop       = rd_data & (fcnt_r != 2'b00);
      case (rxst_r)
         RX_IDLE: begin
            if (csb_r[CSB_RX_EN] & ~rxd & (~sync | smp_ev)) begin
               rxst_nxt  = sync ? RX_BITS : RX_START;
               rxph_nxt  = 4'h0;
               rxbit_nxt = 4'h0;
               // A new start discards the held character.
               if (held_r) begin
                  held_nxt = 1'b0;
                  povr_nxt = 1'b1;
               end
            end
         end
         RX_START: begin
            // Start must still be low at mid bit, else it was a glitch.
            if (tick) begin
               rxph_nxt = rxph_r + 4'h1;
               if (rxph_r == half_m1) begin
                  rxst_nxt = rxd ? RX_IDLE : RX_BITS;
                  rxph_nxt = 4'h0;
               end
            end
         end
         RX_BITS: begin
            if (sync) begin
               samp = smp_ev;
            end else if (tick) begin
               rxph_nxt = (rxph_r == div_m1) ? 4'h0 : rxph_r + 4'h1;
               samp     = rxph_r == div_m1;
            end
         end
         default: rxst_nxt = RX_IDLE;
      endcase
      if (samp) begin
         rxbit_nxt = rxbit_r + 4'h1;
         if (rxbit_r < nbits + {3'b000, par_en}) begin
            rxsh_nxt[rxbit_r] = rxd;
         end else begin
            // First stop bit ends the frame; a second one is never sampled.
            rxst_nxt = RX_IDLE;
            ferr     = ~rxd;
            dat      = rxsh_r[8:0] & ~(9'h1FF << nbits);
            pe       = par_en & (calc_par(dat, nbits, par_odd) != rxsh_r[nbits]);
            entry    = {ferr, povr_r, pe, dat};
            if ((fcnt_r != 2'b10) | pop) begin
               push     = 1'b1;
            end else begin
               held_nxt = 1'b1;
               hold_nxt = entry;
            end
         end
      end
      // The held character moves in as soon as an entry is freed.
      if (held_r & ~held_nxt & ~povr_nxt) begin
         held_nxt = 1'b0;
      end
      if (held_r & (rxst_nxt != RX_START) & (rxst_nxt != RX_BITS | rxst_r == RX_BITS)
          & ((fcnt_r != 2'b10) | pop)) begin
         push     = 1'b1;
         held_nxt = 1'b0;
      end
      if (push) begin
         fifo_nxt[wp_r] = entry;
         if (entry[10] == povr_r) begin
            povr_nxt = 1'b0;
         end
      end
      wp_nxt   = wp_r ^ push;
      rp_nxt   = rp_r ^ pop;
      fcnt_nxt = fcnt_r + {1'b0, push} - {1'b0, pop};
   end

   // Registers of the receiver.
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         rxst_r    <= RX_IDLE;
         rxph_r    <= 4'h0;
         rxbit_r   <= 4'h0;
         rxsh_r    <= 10'h000;
         held_r    <= 1'b0;
         hold_r    <= 12'h000;
         povr_r    <= 1'b0;
         fifo_r[0] <= 12'h000;
         fifo_r[1] <= 12'h000;
         wp_r      <= 1'b0;
         rp_r      <= 1'b0;
         fcnt_r    <= 2'b00;
      end else begin
         rxst_r    <= rxst_nxt;
         rxph_r    <= rxph_nxt;
         rxbit_r   <= rxbit_nxt;
         rxsh_r    <= rxsh_nxt;
         held_r    <= held_nxt;
         hold_r    <= hold_nxt;
         povr_r    <= povr_nxt;
         fifo_r    <= fifo_nxt;
         wp_r      <= wp_nxt;
         rp_r      <= rp_nxt;
         fcnt_r    <= fcnt_nxt;
      end
   end

   // Outputs straight from flip-flops.
   assign prdata  = prdata_r;
   assign pready  = pready_r;
   assign pslverr = pslverr_r;
   assign txd     = txd_r;
   assign lck_out = lck_r;
   assign lck_oe  = lck_oe_r;
endmodule : usart_core

// >>> verif/usart_core_props.sv
/* Port checker for the serial core. Assumes APB master rules at the bus. */
`timescale 1ns/1ps
module usart_core_props
   import usart_pkg::*;
(
   input wire logic        core_clk,
   input wire logic        rstn,
   input wire logic [7:0]  paddr,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        rxd,
   input wire logic        txd,
   input wire logic        lck_in,
   input wire logic        lck_out,
   input wire logic        lck_oe
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rstn);
   // A completed write to control register C.
   wire csc_wr = psel && penable && pready && pwrite && paddr == OFS_CSC;
   wire acc    = psel && penable && pready;
   property p_zero_wait; psel && !penable |=> pready; endproperty
   a_zero_wait: assert property (p_zero_wait) else $error("late ready");
   property p_pulse; pready |=> !pready; endproperty
   a_pulse: assert property (p_pulse) else $error("ready held");
   property p_err_zero; pslverr |-> pready && prdata == 32'h0; endproperty
   a_err_zero: assert property (p_err_zero) else $error("bad error read");
   property p_unmapped; acc && paddr > OFS_BAUDH |-> pslverr; endproperty
   a_unmapped: assert property (p_unmapped) else $error("no error");
   property p_mapped; acc && paddr <= OFS_BAUDH && paddr[1:0] == 2'h0 |-> !pslverr; endproperty
   a_mapped: assert property (p_mapped) else $error("false error");
   property p_upper; acc && !pwrite |-> prdata[31:8] == 24'h0; endproperty
   a_upper: assert property (p_upper) else $error("upper bits set");
   property p_start; $fell(txd) |=> !txd; endproperty
   a_start: assert property (p_start) else $error("short start");
   property p_oe; !csc_wr ##1 !csc_wr |=> $stable(lck_oe); endproperty
   a_oe: assert property (p_oe) else $error("pin mode moved");
endmodule : usart_core_props
bind usart_core usart_core_props u_usart_core_props (.core_clk(core_clk), .rstn(rstn),
   .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
   .prdata(prdata), .pready(pready), .pslverr(pslverr), .rxd(rxd), .txd(txd),
   .lck_in(lck_in), .lck_out(lck_out), .lck_oe(lck_oe));

// >>> verif/serial_peer.sv
/* Remote asynchronous transceiver. Assumes bit times in core clock cycles. */
`timescale 1ns/1ps
module serial_peer (
   input  wire logic core_clk,
   input  wire logic txd,
   output logic      rxd
);
   initial rxd = 1'b1; // The line rests high between frames.
   // Sends start, n data bits least first, a given stop level, then idles.
   task automatic send(input logic [8:0] d, input int n, input logic stp, input int bt);
      for (int i = -1; i <= n; i++) begin
         @(posedge core_clk);
         rxd <= (i < 0) ? 1'b0 : (i == n) ? stp : d[i];
         repeat (bt - 1) @(posedge core_clk);
      end
      @(posedge core_clk);
      rxd <= 1'b1;
   endtask : send
   // Waits for a start bit, then samples n bits at their centres.
   task automatic recv(input int n, input int bt, output logic [15:0] q);
      q = 16'h0;
      @(posedge core_clk);
      while (txd !== 1'b0) @(posedge core_clk);
      repeat (bt / 2) @(posedge core_clk);
      for (int i = 0; i < n; i++) begin
         repeat (bt) @(posedge core_clk);
         q[i] = txd;
      end
   endtask : recv
endmodule : serial_peer

// >>> verif/tb.sv
/* Self-checking bench for the serial core. Assumes divisor zero, 16 cycles a bit. */
`timescale 1ns/1ps
module tb;
   import usart_pkg::*;
   logic        core_clk, rstn, psel, penable, pwrite, err, pready, pslverr;
   logic        rxd, txd, lck_in, lck_out, lck_oe;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [15:0] q, q2;
   int          n_mismatch = 0;
   int          cmp_count = 0;
   int          cyc = 0;
   usart_core u_usart_core (.core_clk(core_clk), .rstn(rstn), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .rxd(rxd), .txd(txd), .lck_in(lck_in), .lck_out(lck_out),
      .lck_oe(lck_oe));
   serial_peer u_serial_peer (.core_clk(core_clk), .txd(txd), .rxd(rxd));
   initial begin
      core_clk = 1'b0;
      forever #2 core_clk = ~core_clk;
   end
   task automatic stop_test;
      if (n_mismatch == 0 && cmp_count > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : stop_test
   // Cuts a hang short.
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_mismatch++;
         stop_test();
      end
   end
   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      cmp_count++;
      if (g !== e) begin
         n_mismatch++;
         $display("ERROR %0t: got %h expected %h", $time, g, e);
      end
   endtask : chk
   // One APB transfer; read data and error land in rd and err.
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      @(posedge core_clk);
      while (pready !== 1'b1) @(posedge core_clk);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic t_regs;
      apb(1'b0, OFS_CSC, 32'h0);
      chk(rd[15:0], {8'h0, CSC_RST});
      apb(1'b0, 8'h18, 32'h0);
      chk({rd[14:0], err}, 16'h1);
   endtask : t_regs
   // Two frames queued back to back through the write buffer.
   task automatic t_tx;
      apb(1'b1, OFS_BAUDL, 32'h0);
      apb(1'b1, OFS_CSB, 32'h18);
      fork
         begin
            u_serial_peer.recv(9, 16, q);
            chk(q, 16'h155);
            u_serial_peer.recv(9, 16, q2);
            chk(q2, 16'h1A3);
         end
         begin
            apb(1'b1, OFS_DATA, 32'h55);
            do apb(1'b0, OFS_CSA, 32'h0); while (rd[CSA_TX_EMPTY] !== 1'b1);
            apb(1'b1, OFS_DATA, 32'hA3);
         end
      join
   endtask : t_tx
   // Parity bit after the data, then the stop bit.
   task automatic t_par(input logic [7:0] csc, input logic [15:0] e);
      repeat (20) @(posedge core_clk);
      apb(1'b1, OFS_CSC, {24'h0, csc});
      fork
         u_serial_peer.recv(10, 16, q);
         apb(1'b1, OFS_DATA, 32'h57);
      join
      chk(q, e);
   endtask : t_par
   // A good frame then one with a low stop bit, both held in the FIFO.
   task automatic t_rx;
      apb(1'b1, OFS_CSC, 32'h6);
      u_serial_peer.send(9'h3C, 8, 1'b1, 16);
      u_serial_peer.send(9'hC3, 8, 1'b0, 16);
      repeat (20) @(posedge core_clk);
      apb(1'b0, OFS_CSA, 32'h0);
      chk({rd[CSA_RX_AVAIL], rd[CSA_FERR]}, 16'h2);
      apb(1'b0, OFS_DATA, 32'h0);
      chk(rd[15:0], 16'h3C);
      apb(1'b0, OFS_CSA, 32'h0);
      chk({rd[CSA_RX_AVAIL], rd[CSA_FERR]}, 16'h3);
      apb(1'b0, OFS_DATA, 32'h0);
      chk(rd[15:0], 16'hC3);
   endtask : t_rx
   // Clock pin drives only in synchronous master mode.
   task automatic t_sync;
      apb(1'b1, OFS_CSC, 32'hC6);
      repeat (3) @(posedge core_clk);
      chk({15'h0, lck_oe}, 16'h1);
      q[0] = lck_out;
      @(posedge core_clk);
      chk({15'h0, lck_out}, {15'h0, ~q[0]});
      apb(1'b1, OFS_CSC, 32'h46);
      repeat (3) @(posedge core_clk);
      chk({15'h0, lck_oe}, 16'h0);
   endtask : t_sync
   // Slave clock at an eighth of the core clock; each bit is read at a falling edge.
   task automatic t_slave;
      apb(1'b1, OFS_DATA, 32'hA5);
      q = 16'h0;
      for (int i = 0; i < 12; i++) begin
         repeat (4) @(posedge core_clk);
         lck_in <= 1'b1;
         repeat (4) @(posedge core_clk);
         lck_in <= 1'b0;
         q[i] = txd;
      end
      chk(q, 16'h0F4A);
   endtask : t_slave
   initial begin
      rstn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h0;
      pwdata = 32'h0;
      lck_in = 1'b0;
      repeat (6) @(posedge core_clk);
      rstn <= 1'b1;
      t_regs();
      t_tx();
      t_par(8'h26, 16'h357);
      t_par(8'h36, 16'h257);
      t_rx();
      t_sync();
      t_slave();
      stop_test();
   end
endmodule : tb
